// File: event_source.sv
// far-side model: capture pins and external timer clock
// assumes rising active edges; the bench calls strike()
`timescale 1ns/1ns
`default_nettype none
module event_source (
   input  wire logic i_ext_run,            // let the external tick run
   output logic      o_capture_input_one,  // trigger pin
   output logic      o_capture_input_two,  // second capture pin
   output logic      o_ext_timer_clk       // external tick
);
   // idle low so only a commanded rise is an active edge
   initial begin
      o_capture_input_one = 1'b0;
      o_capture_input_two = 1'b0;
      o_ext_timer_clk     = 1'b0;
   end
   // 166 ns tick, drifts against i_clk; parked low when stopped
   always begin
      #83;
      o_ext_timer_clk = i_ext_run ? ~o_ext_timer_clk : 1'b0;
   end
   // one edge, held far past the three sync stages
   task automatic strike(input bit two);
      o_capture_input_one = ~two;
      o_capture_input_two = two;
      #400;
      o_capture_input_one = 1'b0;
      o_capture_input_two = 1'b0;
   endtask
endmodule // event_source
`default_nettype wire

// File: opm_pwm_pkg.sv
// package for the one-pulse / pwm timer block
// assumes a single 50 mhz clock; no register bus, all control bits are ports
`default_nettype none
package opm_pwm_pkg;
   localparam logic [15:0] restart_value  = 16'hfffc;  // counter load on trigger / period end
   localparam logic [15:0] capture_mark   = 16'hfffd;  // capture one value on trigger
   localparam logic [15:0] compare_reset  = 16'h8000;  // compare register reset value
   localparam logic [15:0] counter_reset  = 16'hfffc;  // counter reset value
   localparam logic [1:0]  prescaler_factor_div2     = 2'h0;      // prescaler select codes
   localparam logic [1:0]  prescaler_factor_div4     = 2'h1;
   localparam logic [1:0]  prescaler_factor_div8     = 2'h2;
   localparam logic [1:0]  prescaler_factor_ext      = 2'h3;

   // control bits from the cpu side
   typedef struct packed {
      logic       one_pulse_select;
      logic       pwm_select;
      logic       after_pulse_level;
      logic       during_pulse_level;
      logic       trigger_edge_select;
      logic       capture_two_edge_select;
      logic       compare_one_pin_enable;
      logic       capture_irq_enable;
      logic       compare_irq_enable;
      logic       global_irq_mask;
      logic [1:0] prescaler_select;
   } timer_ctrl_t;

   // cpu register access strobes (one-cycle pulses)
   typedef struct packed {
      logic       flag_reg_read;
      logic       cap1_low_access;
      logic       cap2_low_access;
      logic       cmp1_high_wr;
      logic       cmp1_low_wr;
      logic       cmp2_high_wr;
      logic       cmp2_low_wr;
      logic [7:0] wr_data;
   } cpu_access_t;

   // status flags seen by the cpu
   typedef struct packed {
      logic capture_one_flag;
      logic capture_two_flag;
      logic compare_one_flag;
      logic compare_two_flag;
   } timer_flags_t;

   typedef enum logic [1:0] {
      mode_plain     = 2'b00,
      mode_one_pulse = 2'b01,
      mode_pwm       = 2'b10
   } timer_mode_t;
endpackage
`default_nettype wire

// File: opm_pwm_timer.sv
// one-pulse and pwm waveform logic of a 16-bit free-running timer
// assumes cpu strobes on i_clk; capture pins and ext clock are asynchronous
//
// Overview of operation
// - one-pulse select uses capture one, compare one
// - trigger: load fffc, pulse level, flag, fffd
// - capture one flag raises irq when enabled
// - flag clears after status read then low-byte access
// - compare one match drives after-pulse level
// - one-pulse never sets compare one flag
// - both selects set means pwm only
// - equal levels give constant output
// - capture one no capture; capture two works
// - compare two flags time, no waveform
// - pwm period by compare two, pulse by one
// - pwm compare values buffered until period end
// - pwm: match one after-level, match two during-level
// - pwm compare two match reloads fffc
// - high byte write suspends compare until low
// - pwm sets neither compare flag
// - pwm period end sets capture one flag
// - pwm disconnects capture one; capture two works
// - reduced variant: compare two write-only, capture two absent
// - pwm positive pulse is compare difference
// - pin driven only with pin enable set
`timescale 1ns/1ns
`default_nettype none
module opm_pwm_timer #(
   parameter bit reduced_variant = 1'b0   // 1: second capture absent, second compare write-only
) (
   input  wire logic                       i_clk,
   input  wire logic                       i_nrst,
   input  wire opm_pwm_pkg::timer_ctrl_t   i_ctrl,
   input  wire opm_pwm_pkg::cpu_access_t   i_cpu,
   input  wire logic                       i_capture_input_one,
   input  wire logic                       i_capture_input_two,
   input  wire logic                       i_ext_timer_clk,
   output logic                            o_compare_output_pin,
   output logic                            o_compare_output_pin_oe,
   output opm_pwm_pkg::timer_flags_t       o_flags,
   output logic                            o_timer_irq,
   output logic [15:0]                     o_counter,
   output logic [15:0]                     o_capture_one_value,
   output logic [15:0]                     o_capture_two_value,
   output logic [15:0]                     o_compare_one_value,
   output logic [15:0]                     o_compare_two_value
);

   // input synchronisers: three stages, first stage read only by the second
   // the third stage only feeds the edge detectors: one cycle of trigger
   // latency traded for an edge never taken from a settling flop
   logic [2:0] cap1_sync_reg, cap2_sync_reg, ext_sync_reg;
   logic [2:0] cap1_sync_next, cap2_sync_next, ext_sync_next;

   // timer state
   logic [15:0] counter_reg, counter_next;          // free-running counter
   logic [2:0]  prescaler_factor_reg, prescaler_factor_next;              // prescaler divider
   logic [15:0] cmp1_reg, cmp1_next;                // compare one as written
   logic [15:0] cmp2_reg, cmp2_next;                // compare two as written
   logic [15:0] cmp1_act_reg, cmp1_act_next;        // pwm working copies
   logic [15:0] cmp2_act_reg, cmp2_act_next;
   logic        cmp1_inhib_reg, cmp1_inhib_next;    // high byte written, low pending
   logic        cmp2_inhib_reg, cmp2_inhib_next;
   logic [15:0] cap1_reg, cap1_next;
   logic [15:0] cap2_reg, cap2_next;
   logic        capture_one_flag_reg, capture_one_flag_next, capture_two_flag_reg, capture_two_flag_next;
   logic        compare_one_flag_reg, compare_one_flag_next, compare_two_flag_reg, compare_two_flag_next;
   logic        arm1_reg, arm1_next, arm2_reg, arm2_next;   // status read armed clear
   logic        arm3_reg, arm3_next, arm4_reg, arm4_next;
   logic        pin_reg, pin_next;                  // output latch, low in reset
   logic        irq_reg, irq_next;

   // combinational helpers
   opm_pwm_pkg::timer_mode_t mode;
   logic tick;            // one timer tick
   logic edge1, edge2;    // valid active edges
   logic match1, match2;  // compare matches this tick
   logic [15:0] use1, use2;

   // mode decode: pwm dominates when both are set
   always_comb begin
      if (i_ctrl.pwm_select)
         mode = opm_pwm_pkg::mode_pwm;
      else if (i_ctrl.one_pulse_select)
         mode = opm_pwm_pkg::mode_one_pulse;
      else
         mode = opm_pwm_pkg::mode_plain;
   end

   // synchroniser next values
   always_comb begin
      cap1_sync_next = {cap1_sync_reg[1:0], i_capture_input_one};
      cap2_sync_next = {cap2_sync_reg[1:0], i_capture_input_two};
      ext_sync_next  = {ext_sync_reg[1:0], i_ext_timer_clk};
   end

   // edge detection only on stages two and three
   always_comb begin
      edge1 = i_ctrl.trigger_edge_select ? (cap1_sync_reg[1] & ~cap1_sync_reg[2])
                                         : (~cap1_sync_reg[1] & cap1_sync_reg[2]);
      edge2 = i_ctrl.capture_two_edge_select ? (cap2_sync_reg[1] & ~cap2_sync_reg[2])
                                             : (~cap2_sync_reg[1] & cap2_sync_reg[2]);
   end

   // prescaler: one-cycle tick enable
   always_comb begin
      prescaler_factor_next = prescaler_factor_reg + 3'h1;
      unique case (i_ctrl.prescaler_select)
         opm_pwm_pkg::prescaler_factor_div2: tick = prescaler_factor_reg[0];
         opm_pwm_pkg::prescaler_factor_div4: tick = &prescaler_factor_reg[1:0];
         opm_pwm_pkg::prescaler_factor_div8: tick = &prescaler_factor_reg;
         opm_pwm_pkg::prescaler_factor_ext:  tick = ext_sync_reg[1] & ~ext_sync_reg[2];  // rising edge
      endcase
   end

   // compare sources: pwm uses buffered copies
   always_comb begin
      use1   = (mode == opm_pwm_pkg::mode_pwm) ? cmp1_act_reg : cmp1_reg;
      use2   = (mode == opm_pwm_pkg::mode_pwm) ? cmp2_act_reg : cmp2_reg;
      match1 = tick & ~cmp1_inhib_reg & (counter_reg == use1);
      match2 = tick & ~cmp2_inhib_reg & (counter_reg == use2);
   end

   // main timer next-state logic
   always_comb begin
      counter_next  = counter_reg;
      cmp1_next     = cmp1_reg;
      cmp2_next     = cmp2_reg;
      cmp1_act_next = cmp1_act_reg;
      cmp2_act_next = cmp2_act_reg;
      cmp1_inhib_next = cmp1_inhib_reg;
      cmp2_inhib_next = cmp2_inhib_reg;
      cap1_next = cap1_reg;
      cap2_next = cap2_reg;
      capture_one_flag_next = capture_one_flag_reg;
      capture_two_flag_next = capture_two_flag_reg;
      compare_one_flag_next = compare_one_flag_reg;
      compare_two_flag_next = compare_two_flag_reg;
      arm1_next = arm1_reg;
      arm2_next = arm2_reg;
      arm3_next = arm3_reg;
      arm4_next = arm4_reg;
      pin_next  = pin_reg;

      // counter advances one per tick, wrapping
      if (tick)
         counter_next = counter_reg + 16'h0001;

      // compare register writes; high byte suspends the compare
      if (i_cpu.cmp1_high_wr) begin
         cmp1_next[15:8] = i_cpu.wr_data;
         cmp1_inhib_next = 1'b1;
      end
      if (i_cpu.cmp1_low_wr) begin
         cmp1_next[7:0]  = i_cpu.wr_data;
         cmp1_inhib_next = 1'b0;
      end
      if (i_cpu.cmp2_high_wr) begin
         cmp2_next[15:8] = i_cpu.wr_data;
         cmp2_inhib_next = 1'b1;
      end
      if (i_cpu.cmp2_low_wr) begin
         cmp2_next[7:0]  = i_cpu.wr_data;
         cmp2_inhib_next = 1'b0;
      end

      // flag clear: status read arms, low-byte access clears
      if (i_cpu.flag_reg_read) begin
         arm1_next = capture_one_flag_reg;
         arm2_next = capture_two_flag_reg;
         arm3_next = compare_one_flag_reg;
         arm4_next = compare_two_flag_reg;
      end
      if (i_cpu.cap1_low_access && arm1_reg) begin
         capture_one_flag_next = 1'b0;
         arm1_next = 1'b0;
      end
      if (i_cpu.cap2_low_access && arm2_reg) begin
         capture_two_flag_next = 1'b0;
         arm2_next = 1'b0;
      end
      if (i_cpu.cmp1_low_wr && arm3_reg) begin
         compare_one_flag_next = 1'b0;
         arm3_next = 1'b0;
      end
      if (i_cpu.cmp2_low_wr && arm4_reg) begin
         compare_two_flag_next = 1'b0;
         arm4_next = 1'b0;
      end

      // capture two stays usable in every mode; sets win over clears
      if (edge2 && !reduced_variant) begin
         cap2_next = counter_reg;
         capture_two_flag_next = 1'b1;
      end

      unique case (mode)
         opm_pwm_pkg::mode_one_pulse: begin
            // compare two still flags elapsed time, no pin effect
            if (match2)
               compare_two_flag_next = 1'b1;
            // compare one ends the pulse, never flags
            if (match1)
               pin_next = i_ctrl.after_pulse_level;
            // trigger restarts the pulse, also mid-pulse
            if (edge1) begin
               counter_next = opm_pwm_pkg::restart_value;
               pin_next     = i_ctrl.during_pulse_level;
               capture_one_flag_next    = 1'b1;
               cap1_next    = opm_pwm_pkg::capture_mark;
            end
            // pwm copies track writes here too, so a switch to pwm
            // starts from what software wrote, not a stale reset value
            cmp1_act_next = cmp1_next;
            cmp2_act_next = cmp2_next;
         end
         opm_pwm_pkg::mode_pwm: begin
            // no compare flags, capture one pin ignored
            if (match1)
               pin_next = i_ctrl.after_pulse_level;
            if (match2) begin
               pin_next      = i_ctrl.during_pulse_level;
               counter_next  = opm_pwm_pkg::restart_value;
               capture_one_flag_next     = 1'b1;
               cmp1_act_next = cmp1_next;
               cmp2_act_next = cmp2_next;
            end
         end
         opm_pwm_pkg::mode_plain: begin
            // plain compare and capture, kept minimal
            if (match1) begin
               compare_one_flag_next = 1'b1;
               pin_next  = i_ctrl.after_pulse_level;
            end
            if (match2)
               compare_two_flag_next = 1'b1;
            if (edge1) begin
               cap1_next = counter_reg;
               capture_one_flag_next = 1'b1;
            end
            // keep pwm copies fresh so pwm starts with current values
            cmp1_act_next = cmp1_next;
            cmp2_act_next = cmp2_next;
         end
         default: begin
         end
      endcase

      // reduced variant holds second capture and compare flags low
      if (reduced_variant) begin
         capture_two_flag_next = 1'b0;
         compare_two_flag_next = 1'b0;
         cap2_next = 16'h0000;
      end
   end

   // interrupt: capture flags need enable, global mask clear
   // built from the next flags so the request rises with its flag
   always_comb begin
      irq_next = ~i_ctrl.global_irq_mask &
                 ((i_ctrl.capture_irq_enable & (capture_one_flag_next | capture_two_flag_next)) |
                  (i_ctrl.compare_irq_enable & (compare_one_flag_next | compare_two_flag_next)));
   end

   // register all state
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cap1_sync_reg  <= 3'h0;
         cap2_sync_reg  <= 3'h0;
         ext_sync_reg   <= 3'h0;
         prescaler_factor_reg      <= 3'h0;
         counter_reg    <= opm_pwm_pkg::counter_reset;
         cmp1_reg       <= opm_pwm_pkg::compare_reset;
         cmp2_reg       <= opm_pwm_pkg::compare_reset;
         cmp1_act_reg   <= opm_pwm_pkg::compare_reset;
         cmp2_act_reg   <= opm_pwm_pkg::compare_reset;
         cmp1_inhib_reg <= 1'b0;
         cmp2_inhib_reg <= 1'b0;
         cap1_reg       <= 16'h0000;
         cap2_reg       <= 16'h0000;
         capture_one_flag_reg       <= 1'b0;
         capture_two_flag_reg       <= 1'b0;
         compare_one_flag_reg       <= 1'b0;
         compare_two_flag_reg       <= 1'b0;
         arm1_reg       <= 1'b0;
         arm2_reg       <= 1'b0;
         arm3_reg       <= 1'b0;
         arm4_reg       <= 1'b0;
         pin_reg        <= 1'b0;
         irq_reg        <= 1'b0;
      end else begin
         cap1_sync_reg  <= cap1_sync_next;
         cap2_sync_reg  <= cap2_sync_next;
         ext_sync_reg   <= ext_sync_next;
         prescaler_factor_reg      <= prescaler_factor_next;
         counter_reg    <= counter_next;
         cmp1_reg       <= cmp1_next;
         cmp2_reg       <= cmp2_next;
         cmp1_act_reg   <= cmp1_act_next;
         cmp2_act_reg   <= cmp2_act_next;
         cmp1_inhib_reg <= cmp1_inhib_next;
         cmp2_inhib_reg <= cmp2_inhib_next;
         cap1_reg       <= cap1_next;
         cap2_reg       <= cap2_next;
         capture_one_flag_reg       <= capture_one_flag_next;
         capture_two_flag_reg       <= capture_two_flag_next;
         compare_one_flag_reg       <= compare_one_flag_next;
         compare_two_flag_reg       <= compare_two_flag_next;
         arm1_reg       <= arm1_next;
         arm2_reg       <= arm2_next;
         arm3_reg       <= arm3_next;
         arm4_reg       <= arm4_next;
         pin_reg        <= pin_next;
         irq_reg        <= irq_next;
      end
   end

   // outputs straight from flip-flops; pin enable is the pin enable control bit registered once
   logic oe_reg;
   always_ff @(posedge i_clk) begin
      if (!i_nrst)
         oe_reg <= 1'b0;
      else
         oe_reg <= i_ctrl.compare_one_pin_enable;
   end

   assign o_compare_output_pin    = pin_reg;
   assign o_compare_output_pin_oe = oe_reg;
   assign o_flags = '{capture_one_flag: capture_one_flag_reg, capture_two_flag: capture_two_flag_reg,
                      compare_one_flag: compare_one_flag_reg, compare_two_flag: compare_two_flag_reg};
   assign o_timer_irq          = irq_reg;
   assign o_counter            = counter_reg;
   assign o_capture_one_value  = cap1_reg;
   assign o_capture_two_value  = cap2_reg;
   assign o_compare_one_value  = cmp1_reg;
   // reduced variant: compare two reads undefined; zero given here
   assign o_compare_two_value  = reduced_variant ? 16'h0000 : cmp2_reg;

endmodule // opm_pwm_timer
`default_nettype wire

// File: opm_pwm_timer_properties.sv
// port checker for the one-pulse / pwm timer
// assumes a bind onto opm_pwm_timer and a single clock domain
`timescale 1ns/1ns
`default_nettype none
module opm_pwm_timer_properties (
   input wire logic                      i_clk,
   input wire logic                      i_nrst,
   input wire opm_pwm_pkg::timer_ctrl_t  i_ctrl,
   input wire logic                      o_compare_output_pin,
   input wire logic                      o_compare_output_pin_oe,
   input wire opm_pwm_pkg::timer_flags_t o_flags,
   input wire logic                      o_timer_irq,
   input wire logic [15:0]               o_counter,
   input wire logic [15:0]               o_capture_one_value
);
   logic opm;  // one-pulse only, pwm wins when both set
   logic pwm;  // pwm active
   logic eq;   // both levels programmed alike
   assign pwm = i_ctrl.pwm_select;
   assign opm = i_ctrl.one_pulse_select & ~i_ctrl.pwm_select;
   assign eq  = i_ctrl.after_pulse_level == i_ctrl.during_pulse_level;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   AST_OE_LATE: assert property ($past(i_nrst) |-> o_compare_output_pin_oe == $past(i_ctrl.compare_one_pin_enable))
      else $error("pin enable does not follow control");
   AST_TRIG_LOAD: assert property ($past(opm) && $rose(o_flags.capture_one_flag) |->
      o_counter == 16'hfffc && o_capture_one_value == 16'hfffd && o_compare_output_pin == $past(i_ctrl.during_pulse_level))
      else $error("trigger did not load counter, capture and pin");
   AST_OPM_NO_CMP1: assert property ($past(opm) |-> !$rose(o_flags.compare_one_flag))
      else $error("compare one flag set in one-pulse mode");
   AST_PWM_NO_CMP: assert property ($past(pwm) |-> !$rose(o_flags.compare_one_flag) && !$rose(o_flags.compare_two_flag))
      else $error("compare flag set in pwm mode");
   AST_EQUAL_LVL: assert property ($past(opm | pwm) && $past(eq) && $past(o_compare_output_pin) == $past(i_ctrl.after_pulse_level)
      |-> o_compare_output_pin == $past(i_ctrl.after_pulse_level))
      else $error("pin moved with equal levels");
   AST_IRQ_CAP: assert property ($rose(o_flags.capture_one_flag) && i_ctrl.capture_irq_enable && !i_ctrl.global_irq_mask
      |-> ##[0:1] o_timer_irq)
      else $error("capture flag raised no interrupt");
   AST_PWM_RELOAD: assert property ($past(pwm) && $rose(o_flags.capture_one_flag) |-> o_counter == 16'hfffc)
      else $error("period end did not reload counter");
   AST_CNT_STEP: assert property ($past(i_nrst) && o_counter != $past(o_counter)
      |-> o_counter == $past(o_counter) + 16'h1 || o_counter == 16'hfffc)
      else $error("counter jumped");
endmodule // opm_pwm_timer_properties
bind opm_pwm_timer opm_pwm_timer_properties i_props (.i_clk(i_clk), .i_nrst(i_nrst), .i_ctrl(i_ctrl),
   .o_compare_output_pin(o_compare_output_pin), .o_compare_output_pin_oe(o_compare_output_pin_oe),
   .o_flags(o_flags), .o_timer_irq(o_timer_irq), .o_counter(o_counter), .o_capture_one_value(o_capture_one_value));
`default_nettype wire

// File: tb_top.sv
// bench for the one-pulse / pwm timer
// assumes event_source on the pins and the port checker bound in
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin err_total++; $display("unexpected at %0t: %s", $time, m); end end
module tb_top;
   logic                      i_clk = 1'b0;    // 50 mhz
   logic                      i_nrst = 1'b0;   // sync, active low
   logic                      ext_run = 1'b0;  // external tick enable
   opm_pwm_pkg::timer_ctrl_t  ctrl = '0;       // control bits
   opm_pwm_pkg::cpu_access_t  cpu = '0;        // cpu strobes
   opm_pwm_pkg::timer_flags_t flags;
   logic                      cap1, cap2, ext_clk, pin, irq, oe;
   logic [15:0]               cnt, cap1_val, cap2_val, cmp1_val, cmp2_val;
   logic [15:0]               cnt0;            // counter just before the second capture edge
   int                        err_total = 0;
   int                        checked = 0;
   int                        n, m, h;
   int                        divs [4] = '{2, 4, 8, 8};  // ext tick taken as about 8 cycles

   event_source i_event_source (.i_ext_run(ext_run), .o_capture_input_one(cap1),
      .o_capture_input_two(cap2), .o_ext_timer_clk(ext_clk));
   opm_pwm_timer i_opm_pwm_timer (.i_clk(i_clk), .i_nrst(i_nrst), .i_ctrl(ctrl), .i_cpu(cpu),
      .i_capture_input_one(cap1), .i_capture_input_two(cap2), .i_ext_timer_clk(ext_clk),
      .o_compare_output_pin(pin), .o_compare_output_pin_oe(oe), .o_flags(flags), .o_timer_irq(irq),
      .o_counter(cnt), .o_capture_one_value(cap1_val), .o_capture_two_value(cap2_val),
      .o_compare_one_value(cmp1_val), .o_compare_two_value(cmp2_val));

   // free-running clock
   always #10 i_clk = ~i_clk;

   // verdict, then stop
   task automatic test_done;
      if (err_total == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // count cycles until pin shows lvl (or counter reloads); bounded
   task automatic wait_for(input bit on_cnt, input logic lvl, output int c);
      c = 0;
      while (on_cnt ? cnt !== opm_pwm_pkg::restart_value : pin !== lvl) begin
         @(negedge i_clk);
         c++;
         if (c > 4000) begin
            err_total++;
            $display("unexpected at %0t: wait timed out", $time);
            test_done();
         end
      end
   endtask

   // one-cycle strobe; a quiet cycle after so strobes never merge
   task automatic cpu_pulse(input opm_pwm_pkg::cpu_access_t a);
      cpu = a;
      @(negedge i_clk);
      cpu = '0;
      @(negedge i_clk);
   endtask

   // compare write, high byte first; low byte optional
   task automatic wr_cmp(input bit two, input logic [15:0] v, input bit low_too);
      cpu_pulse('{cmp2_high_wr: two, cmp1_high_wr: ~two, wr_data: v[15:8], default: '0});
      if (low_too)
         cpu_pulse('{cmp2_low_wr: two, cmp1_low_wr: ~two, wr_data: v[7:0], default: '0});
   endtask

   // main sequence, everything driven on the falling edge
   initial begin
      repeat (2) @(negedge i_clk);
      i_nrst = 1'b1;
      `CHK(cnt, opm_pwm_pkg::counter_reset, "counter reset value")
      `CHK(pin, 1'b0, "pin reset level")
      `CHK(oe, 1'b0, "pin enable reset level")
      wr_cmp(1'b0, 16'h000a, 1'b1);
      ctrl.one_pulse_select = 1'b1;
      ctrl.during_pulse_level = 1'b1;
      ctrl.trigger_edge_select = 1'b1;
      ctrl.capture_two_edge_select = 1'b1;
      ctrl.compare_one_pin_enable = 1'b1;
      ctrl.capture_irq_enable = 1'b1;
      ext_run = 1'b1;
      // pulse length for every tick source
      for (int k = 0; k < 4; k++) begin
         ctrl.prescaler_select = 2'(k);
         @(negedge i_clk);
         fork i_event_source.strike(1'b0); join_none
         wait_for(1'b0, 1'b1, n);
         wait_for(1'b0, 1'b0, m);
         `CHK(m >= 12 * divs[k] && m <= 18 * divs[k], 1'b1, "pulse length")
      end
      ext_run = 1'b0;
      ctrl.prescaler_select = opm_pwm_pkg::prescaler_factor_div2;
      `CHK(cap1_val, opm_pwm_pkg::capture_mark, "trigger capture value")
      `CHK(irq, 1'b1, "capture interrupt")
      `CHK(oe, 1'b1, "pin enable not followed")
      `CHK(flags.compare_one_flag, 1'b0, "compare one flag in one-pulse")
      cpu_pulse('{cap1_low_access: 1'b1, default: '0});
      `CHK(flags.capture_one_flag, 1'b1, "flag cleared without status read")
      cpu_pulse('{flag_reg_read: 1'b1, default: '0});
      cpu_pulse('{cap1_low_access: 1'b1, default: '0});
      `CHK(flags.capture_one_flag, 1'b0, "flag not cleared")
      // div 2: exactly one tick lands before the third sync edge captures
      cnt0 = cnt;
      i_event_source.strike(1'b1);
      `CHK(flags.capture_two_flag, 1'b1, "second capture in one-pulse")
      `CHK(cap2_val, cnt0 + 16'h0001, "second capture value")
      // retrigger mid-pulse stretches the pulse
      fork i_event_source.strike(1'b0); join_none
      wait_for(1'b0, 1'b1, n);
      repeat (20) @(negedge i_clk);
      fork i_event_source.strike(1'b0); join_none
      wait_for(1'b0, 1'b0, m);
      `CHK(20 + m >= 45 && 20 + m <= 62, 1'b1, "retrigger pulse length")
      // high byte alone holds the compare off
      wr_cmp(1'b0, 16'h0009, 1'b0);
      fork i_event_source.strike(1'b0); join_none
      wait_for(1'b0, 1'b1, n);
      repeat (80) @(negedge i_clk);
      `CHK(pin, 1'b1, "compare not suspended")
      cpu_pulse('{cmp1_low_wr: 1'b1, wr_data: 8'h09, default: '0});
      wr_cmp(1'b1, 16'h0014, 1'b1);
      ctrl.after_pulse_level = 1'b1;
      fork i_event_source.strike(1'b0); join_none
      wait_for(1'b1, 1'b0, n);
      // 20 ticks: past the compare one match at 0009, counter at 0010
      repeat (40) @(negedge i_clk);
      `CHK(pin, 1'b1, "equal levels not constant")
      // pwm with both selects set, counter still short of compare two
      ctrl.pwm_select = 1'b1;
      ctrl.during_pulse_level = 1'b0;
      wait_for(1'b0, 1'b1, n);
      cpu_pulse('{flag_reg_read: 1'b1, default: '0});
      cpu_pulse('{cap1_low_access: 1'b1, default: '0});
      wait_for(1'b0, 1'b0, m);
      `CHK(4 + m >= 8 && 4 + m <= 12, 1'b1, "period end level late")
      `CHK(flags.capture_one_flag, 1'b1, "period end flag")
      // new compare one mid-period, trigger pin poked meanwhile
      fork i_event_source.strike(1'b0); join_none
      wr_cmp(1'b0, 16'h0004, 1'b1);
      wait_for(1'b0, 1'b1, n);
      `CHK(4 + n >= 26 && 4 + n <= 30, 1'b1, "pwm low length")
      wait_for(1'b0, 1'b0, h);
      `CHK(h >= 20 && h <= 24, 1'b1, "pwm high length")
      // the written 0004 only counts from this period end on
      wait_for(1'b0, 1'b1, n);
      `CHK(n >= 16 && n <= 20, 1'b1, "buffered compare not taken")
      wait_for(1'b0, 1'b0, h);
      `CHK(h >= 30 && h <= 34, 1'b1, "pwm high after reload")
      `CHK(n + h >= 48 && n + h <= 52, 1'b1, "pwm period")
      `CHK(flags.compare_one_flag | flags.compare_two_flag, 1'b0, "compare flag in pwm")
      `CHK(cmp1_val, 16'h0004, "compare one as written")
      `CHK(cmp2_val, 16'h0014, "compare two as written")
      // mask and pin enable off: request and driver both drop
      ctrl.global_irq_mask = 1'b1;
      ctrl.compare_one_pin_enable = 1'b0;
      @(negedge i_clk);
      `CHK(irq, 1'b0, "interrupt not masked")
      `CHK(oe, 1'b0, "pin enable not dropped")
      test_done();
   end
endmodule // tb_top
`default_nettype wire
